// file: logic/serial_pixel_deserializer.sv
// Serial-to-parallel pixel receiver: mode sequencing, lane
// deserialisation, odd-parity check and parallel pixel output.
// Assumes the analog front end supplies the PLL line clock, lock
// and common-mode indications as pins; all are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "deser_cfg.svh"

// Behaviour
// - Lane pins pick one, two or three lanes; code 11 never receives.
// - One lane: thirty line ticks per frame and per pixel clock.
// - Two lanes: fifteen bits per lane per frame and pixel clock.
// - Three lanes: ten bits per lane per frame.
// - Only the 27 payload bits reach the parallel outputs.
// - Enable low: shutdown, inputs ignored, colour, syncs and link_ready high, others low.
// - Common-mode high or floating clock input forces standby.
// - Forwarded clock below 500 kHz forces standby.
// - Standby ignores lanes, PLL off, outputs show the idle pattern.
// - Enable, clock faster than 3 MHz and low common mode activate.
// - Acquire keeps the idle pattern on every pixel output.
// - Lock enters receive; payload and recreated pixel clock are driven.
// - Parity checked only in receive; no faults otherwise.
// - Odd parity over 27 payload bits plus parity bit.
// - Fault pulse rises with the pixel clock, falls half a pixel later.
// - A failing frame is dropped and the last good payload repeats.
// - Leaving receive switches outputs to the idle pattern at once.
// - Fault pulse lasts half a pixel period, one per bad frame.
module serial_pixel_deserializer (
  input wire logic mclk, // 10 MHz system clock
  input wire logic nrst, // Async reset, active low
  input wire logic receiver_enable_pin, // Enable pin, high runs
  input wire logic lane_select_low, // Lane select, low bit
  input wire logic lane_select_high, // Lane select, high bit
  input wire logic fwd_clk_pin, // Forwarded link clock
  input wire logic line_clk_pin, // PLL line clock
  input wire logic pll_locked_pin, // PLL lock indication
  input wire logic clock_common_mode_level, // High: common mode above 0.9 or floating
  input wire logic cm_below_limit_pin, // High: common mode below 1.3 V
  input wire logic serial_lane_0, // Data lane 0
  input wire logic serial_lane_1, // Data lane 1
  input wire logic serial_lane_2, // Data lane 2
  output logic [23:0] colour_out, // Colour bits
  output logic vertical_sync_out, // Vertical sync
  output logic horizontal_sync_out, // Horizontal sync
  output logic display_enable_out, // Display enable
  output logic pixel_clk_out, // Recreated pixel clock
  output logic parity_fault_pulse, // Parity error pulse
  output logic pll_enable, // PLL power request
  output logic link_ready, // Frame buffer can accept
  output deser_pkg::mode_e mode_out // Current operating mode
);
  import deser_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
    logic fwd_d;
    logic line_d;
    mode_e mode;
    logic [4:0] since_edge;
    logic act;
    logic [4:0] bit_cnt;
    logic [`FRAME_W-1:0] frame;
    logic push;
    logic [`WORD_W-1:0] push_word;
    logic [`COLOUR_W-1:0] colour;
    logic vs;
    logic hs;
    logic de;
    logic pclk;
    logic fault;
  } state_s;

  localparam state_s RESET_ST = '{
    mode: mode_shutdown,
    colour: `IDLE_COLOUR,
    vs: 1'b1,
    hs: 1'b1,
    default: '0
  };

  state_s st_reg;
  state_s st_next;

  logic en;
  logic locked;
  logic cm_high;
  logic cm_low;
  logic fwd_rise;
  logic line_rise;
  logic clk_slow;
  logic clk_lost;
  logic [1:0] lane_code;
  logic lane_ok;
  logic [1:0] n_lanes;
  logic [4:0] bpl;
  logic rx;
  logic [4:0] base;
  logic [4:0] idx;
  logic [`FRAME_W-1:0] frame_now;
  logic done;
  logic bad;
  logic pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`WORD_W-1:0] fifo_out_data;
  logic fifo_flush;

  // ----------------------------------------------------------------
  // Synchronised pin views
  // ----------------------------------------------------------------
  // Only the second stage is read; the first feeds it alone
  assign en = st_reg.s2[`SY_EN];
  assign locked = st_reg.s2[`SY_LOCK];
  assign cm_high = st_reg.s2[`SY_CMHI];
  assign cm_low = st_reg.s2[`SY_CMLO];
  assign fwd_rise = st_reg.s2[`SY_FWD] & ~st_reg.fwd_d;
  assign line_rise = st_reg.s2[`SY_LINE] & ~st_reg.line_d;
  assign lane_code = {st_reg.s2[`SY_LS_HI], st_reg.s2[`SY_LS_LO]};
  assign clk_slow = st_reg.since_edge >= `SLOW_CYC;
  assign clk_lost = clk_slow | cm_high;
  assign rx = st_reg.mode == mode_receive;

  // Lane configuration decode; reserved code yields no valid setting
  always_comb begin
    lane_ok = 1'b1;
    n_lanes = 2'd1;
    bpl = `BPL_ONE;
    case (lane_cfg_e'(lane_code))
      one_lane_config: begin
        n_lanes = 2'd1;
        bpl = `BPL_ONE;
      end
      two_lane_config: begin
        n_lanes = 2'd2;
        bpl = `BPL_TWO;
      end
      three_lane_config: begin
        n_lanes = 2'd3;
        bpl = `BPL_THREE;
      end
      default: begin
        lane_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Monitor, mode machine, shifter and output stage in one pass
  always_comb begin
    st_next = st_reg;
    base = '0;
    idx = '0;
    frame_now = st_reg.frame;
    done = 1'b0;
    bad = 1'b0;
    pop = 1'b0;
    st_next.s1 = {lane_select_high, lane_select_low, serial_lane_2, serial_lane_1,
                  serial_lane_0, line_clk_pin, fwd_clk_pin, cm_below_limit_pin,
                  clock_common_mode_level, pll_locked_pin, receiver_enable_pin};
    st_next.s2 = st_reg.s1;
    st_next.fwd_d = st_reg.s2[`SY_FWD];
    st_next.line_d = st_reg.s2[`SY_LINE];

    // Clock monitor: spacing of forwarded clock edges in mclk cycles
    if (fwd_rise) begin
      st_next.since_edge = '0;
      st_next.act = st_reg.since_edge < `FAST_CYC;
    end else if (st_reg.since_edge != 5'h1f) begin
      st_next.since_edge = 5'(st_reg.since_edge + 1'b1);
    end
    if (clk_slow) begin
      st_next.act = 1'b0;
    end

    // Mode sequencing; enable low overrides everything
    case (st_reg.mode)
      mode_shutdown: begin
        if (en) begin
          st_next.mode = mode_standby;
        end
      end
      mode_standby: begin
        if (!clk_lost && st_reg.act && cm_low) begin
          st_next.mode = mode_acquire;
        end
      end
      mode_acquire: begin
        if (clk_lost) begin
          st_next.mode = mode_standby;
        end else if (locked && lane_ok) begin
          st_next.mode = mode_receive;
        end
      end
      mode_receive: begin
        if (clk_lost) begin
          st_next.mode = mode_standby;
        end else if (!locked || !lane_ok) begin
          st_next.mode = mode_acquire;
        end
      end
      default: begin
        st_next.mode = mode_shutdown;
      end
    endcase
    if (!en) begin
      st_next.mode = mode_shutdown;
    end

    // Shifter: a forwarded clock edge restarts the frame count
    base = fwd_rise ? 5'd0 : st_reg.bit_cnt;
    st_next.push = 1'b0;
    if (rx && line_rise) begin
      for (int l = 0; l < 3; l++) begin
        idx = 5'(base * 5'(n_lanes) + 5'(l));
        if (2'(l) < n_lanes) begin
          frame_now[idx] = st_reg.s2[`SY_LANE0 + l];
        end
      end
      st_next.frame = frame_now;
      st_next.bit_cnt = 5'(base + 1'b1);
      if (base == 5'(bpl - 1'b1)) begin
        done = 1'b1;
        st_next.bit_cnt = '0;
      end
    end else if (fwd_rise) begin
      st_next.bit_cnt = '0;
    end

    // Odd parity: 27 payload bits plus parity bit must sum odd
    bad = ~(^frame_now[`BIT_PARITY:0]);
    if (done) begin
      st_next.push = 1'b1;
      st_next.push_word = {bad, frame_now[`PAYLOAD_W-1:0]};
    end

    // Recreated pixel clock: high for the first half of each frame
    st_next.pclk = rx && (st_next.bit_cnt < (bpl >> 1));
    pop = rx && fifo_out_valid && !st_reg.pclk && st_next.pclk;

    // Output stage: a bad word keeps the last good payload
    if (pop) begin
      if (fifo_out_data[`WORD_W-1]) begin
        st_next.fault = 1'b1;
      end else begin
        st_next.colour = fifo_out_data[`COLOUR_W-1:0];
        st_next.vs = fifo_out_data[`BIT_VSYNC];
        st_next.hs = fifo_out_data[`BIT_HSYNC];
        st_next.de = fifo_out_data[`BIT_DEN];
        st_next.fault = 1'b0;
      end
    end
    if (!st_next.pclk) begin
      st_next.fault = 1'b0;
    end

    // Any mode but receive shows the idle pattern from this edge on
    if (st_next.mode != mode_receive) begin
      st_next.colour = `IDLE_COLOUR;
      st_next.vs = 1'b1;
      st_next.hs = 1'b1;
      st_next.de = 1'b0;
      st_next.pclk = 1'b0;
      st_next.fault = 1'b0;
      st_next.bit_cnt = '0;
      st_next.push = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= RESET_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Frame buffer between shifter and output stage
  // ----------------------------------------------------------------
  // Flushed outside receive so stale pixels never reappear later
  assign fifo_flush = !rx;

  pixel_fifo #(
    .W(`WORD_W),
    .D(`FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .flush(fifo_flush),
    .in_valid(st_reg.push),
    .in_data(st_reg.push_word),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(pop)
  );

  // Outputs from the state register; link_ready from the FIFO count
  assign colour_out = st_reg.colour;
  assign vertical_sync_out = st_reg.vs;
  assign horizontal_sync_out = st_reg.hs;
  assign display_enable_out = st_reg.de;
  assign pixel_clk_out = st_reg.pclk;
  assign parity_fault_pulse = st_reg.fault;
  assign pll_enable = st_reg.mode == mode_acquire || rx;
  assign link_ready = fifo_in_ready;
  assign mode_out = st_reg.mode;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  idle_pattern_a: assert property (
    st_reg.mode != mode_receive |-> colour_out == `IDLE_COLOUR && vertical_sync_out
      && horizontal_sync_out && !display_enable_out && !pixel_clk_out)
    else $error("idle pattern missing outside receive");

  shutdown_entry_a: assert property (
    !en |=> mode_out == mode_shutdown && colour_out == `IDLE_COLOUR)
    else $error("enable low did not reach shutdown");

  standby_cm_a: assert property (
    en && cm_high && st_reg.mode != mode_shutdown |=> mode_out == mode_standby)
    else $error("high common mode did not force standby");

  slow_clock_a: assert property (
    en && clk_slow && st_reg.mode != mode_shutdown |=> mode_out == mode_standby)
    else $error("slow clock did not force standby");

  no_fault_idle_a: assert property (
    st_reg.mode != mode_receive |-> !parity_fault_pulse)
    else $error("parity fault outside receive");

  reserved_lanes_a: assert property (
    lane_code == 2'b11 && st_reg.mode != mode_receive |=> mode_out != mode_receive)
    else $error("reserved lane code entered receive");

  fault_half_a: assert property (
    $rose(parity_fault_pulse) |-> $rose(pixel_clk_out)
      ##1 (parity_fault_pulse == pixel_clk_out) [*2])
    else $error("fault pulse not tied to pixel clock high phase");

  repeat_good_a: assert property (
    $rose(parity_fault_pulse) |-> $stable(colour_out) && $stable(display_enable_out))
    else $error("bad frame reached the output bus");

  lock_loss_a: assert property (
    rx && en && !locked |=> mode_out != mode_receive && !pixel_clk_out)
    else $error("lock loss did not leave receive");

  pll_power_a: assert property (
    mode_out == mode_standby |-> !pll_enable)
    else $error("PLL powered in standby");

endmodule : serial_pixel_deserializer
`default_nettype wire

// file: logic/deser_cfg.svh
// Constants for the serial pixel deserializer: frame layout, per-lane
// bit counts, synchroniser bit positions and clock-monitor timing.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef DESER_CFG_SVH
`define DESER_CFG_SVH

// ----------------------------------------------------------------
// Frame layout (30-bit frame, identical on both ends of the link)
// ----------------------------------------------------------------
`define FRAME_W 30
`define PAYLOAD_W 27
`define COLOUR_W 24
`define BIT_VSYNC 24
`define BIT_HSYNC 25
`define BIT_DEN 26
`define BIT_PARITY 27
`define WORD_W 28
`define FIFO_DEPTH 8

// ----------------------------------------------------------------
// Lane configurations: bits per lane per frame
// ----------------------------------------------------------------
`define BPL_ONE 5'd30
`define BPL_TWO 5'd15
`define BPL_THREE 5'd10
`define IDLE_COLOUR 24'hffffff

// ----------------------------------------------------------------
// Synchroniser vector bit positions
// ----------------------------------------------------------------
`define SYNC_W 11
`define SY_EN 0
`define SY_LOCK 1
`define SY_CMHI 2
`define SY_CMLO 3
`define SY_FWD 4
`define SY_LINE 5
`define SY_LANE0 6
`define SY_LS_LO 9
`define SY_LS_HI 10

// ----------------------------------------------------------------
// Clock activity monitor timing
// ----------------------------------------------------------------
`define MCLK_KHZ 10000
`define FAST_CLK_KHZ 3000
`define SLOW_CLK_KHZ 500
`define FAST_CYC 5'((`MCLK_KHZ) / (`FAST_CLK_KHZ))
`define SLOW_CYC 5'((`MCLK_KHZ) / (`SLOW_CLK_KHZ))

`endif

// file: logic/deser_pkg.sv
// Types shared by the deserializer files: operating modes and
// lane configuration codes. No assumptions beyond the tool.
package deser_pkg;

  // Operating mode of the receiver
  typedef enum logic [1:0] {
    mode_shutdown = 2'b00,
    mode_standby = 2'b01,
    mode_acquire = 2'b10,
    mode_receive = 2'b11
  } mode_e;

  // Lane-select pin codes, high pin first
  typedef enum logic [1:0] {
    one_lane_config = 2'b00,
    two_lane_config = 2'b01,
    three_lane_config = 2'b10,
    reserved_config = 2'b11
  } lane_cfg_e;

endpackage : deser_pkg

// file: logic/pixel_fifo.sv
// Small flop-based FIFO with valid/ready on both sides.
// Assumes one clock domain and a power-of-two depth.
`timescale 1ns/1ps
`default_nettype none

module pixel_fifo #(
  parameter int W = 28,
  parameter int D = 8
) (
  input wire logic mclk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic flush, // Empties the FIFO
  input wire logic in_valid, // Write request
  input wire logic [W-1:0] in_data, // Write data
  output logic in_ready, // Space available
  output logic out_valid, // Data available
  output logic [W-1:0] out_data, // Head word
  input wire logic out_ready // Read accept
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s st_reg;
  fifo_s st_next;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Handshakes come straight from the count
  // ----------------------------------------------------------------
  assign in_ready = st_reg.cnt != (AW+1)'(D);
  assign out_valid = st_reg.cnt != '0;
  assign out_data = st_reg.mem[st_reg.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update; flush wins over traffic
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = AW'(st_reg.wp + 1'b1);
    end
    if (pop) begin
      st_next.rp = AW'(st_reg.rp + 1'b1);
    end
    st_next.cnt = (AW+1)'(st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    if (flush) begin
      st_next.wp = '0;
      st_next.rp = '0;
      st_next.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : pixel_fifo
`default_nettype wire

// file: sim/link_tx_model.sv
// Transmitter model for the deserializer bench: forwarded clock, line
// clock and three serial lanes, driven through its own tasks.
// Assumes the bench calls one task at a time, from an mclk edge.
`timescale 1ns/1ps
`default_nettype none

module link_tx_model (
  input wire logic mclk, // System clock
  output logic fwd_clk, // Forwarded clock
  output logic line_clk, // Line clock
  output logic [2:0] lane // Serial lanes
);
  logic busy = 1'b0;

  // --------------------------------------------------------------
  // Idle link
  // --------------------------------------------------------------
  // Clocks stand still at power-up
  initial begin
    fwd_clk = 1'b0;
    line_clk = 1'b0;
    lane = 3'h0;
  end

  // Lanes carry no held value outside a frame, so a stale bit cannot pass
  always @(posedge mclk) begin
    if (!busy) lane <= ~lane;
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  // Fast forwarded clock with no frames: 5 MHz keeps clear of the weak
  // lock band, and it always ends low so the next frame starts on a rise
  task automatic preamble(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      fwd_clk <= 1'b1;
      @(posedge mclk);
      fwd_clk <= 1'b0;
    end
  endtask : preamble

  // One frame over n lanes; line ticks every two cycles, clock high for
  // the first half of the frame
  task automatic send_frame(input logic [26:0] pay, input logic bad, input int n);
    logic [29:0] f;
    f = {2'b00, ~(^pay) ^ bad, pay};
    busy = 1'b1;
    for (int b = 0; b < 30 / n; b++) begin
      @(posedge mclk);
      fwd_clk <= (b < 15 / n);
      line_clk <= 1'b1;
      for (int l = 0; l < 3; l++) lane[l] <= (l < n) ? f[b * n + l] : ~lane[l];
      @(posedge mclk);
      line_clk <= 1'b0;
    end
    busy = 1'b0;
  endtask : send_frame
endmodule : link_tx_model
`default_nettype wire

// file: sim/test_serial_pixel_deserializer.sv
// Self-checking bench for the serial pixel deserializer: modes, lane
// codes, payload delivery and parity handling against a queue model.
// Assumes link_tx_model drives the link pins from its tasks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t got %0h exp %0h", $time, got, exp); end end

module test_serial_pixel_deserializer;
  import deser_pkg::*;
  logic mclk;
  logic nrst;
  logic en;
  logic lock;
  logic cm_high;
  logic cm_ok;
  logic [1:0] ls;
  logic fwd, line_ck, vs, hs, de, pclk, fault, pll_en, rdy;
  logic [2:0] lane;
  logic [23:0] colour;
  mode_e mode;
  int miscompares = 0;
  int num_checks = 0;
  logic [27:0] exp_q[$];
  logic [27:0] e;
  logic [26:0] got;
  logic [26:0] last_good = 27'h3ffffff;
  logic pclk_prev = 1'b0;
  logic primed = 1'b0;
  logic bad;
  logic [31:0] rnd = 32'h176db;

  // --------------------------------------------------------------
  // Design, partner and clock
  // --------------------------------------------------------------
  serial_pixel_deserializer uut (
    .mclk(mclk), .nrst(nrst), .receiver_enable_pin(en), .lane_select_low(ls[0]),
    .lane_select_high(ls[1]), .fwd_clk_pin(fwd), .line_clk_pin(line_ck),
    .pll_locked_pin(lock), .clock_common_mode_level(cm_high), .cm_below_limit_pin(cm_ok),
    .serial_lane_0(lane[0]), .serial_lane_1(lane[1]), .serial_lane_2(lane[2]),
    .colour_out(colour), .vertical_sync_out(vs), .horizontal_sync_out(hs),
    .display_enable_out(de), .pixel_clk_out(pclk), .parity_fault_pulse(fault),
    .pll_enable(pll_en), .link_ready(rdy), .mode_out(mode)
  );
  link_tx_model tx (.mclk(mclk), .fwd_clk(fwd), .line_clk(line_ck), .lane(lane));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // --------------------------------------------------------------
  // Model and helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Sampled mid-cycle, so every edge update has landed. The frame buffer
  // adds one pixel of latency: the first pixel rise of a run shows nothing
  // new, and each later rise shows the frame before the one just finished
  always @(negedge mclk) begin
    got = {de, hs, vs, colour};
    if (mode !== mode_receive) begin
      primed = 1'b0;
      `CHK({got, pclk, fault}, {27'h3ffffff, 2'b00})
    end else if (pclk === 1'b1 && pclk_prev === 1'b0 && exp_q.size() > 0 && !primed) begin
      primed = 1'b1;
      `CHK(got, last_good)
    end else if (pclk === 1'b1 && pclk_prev === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (!e[27]) last_good = e[26:0];
      `CHK(got, last_good)
      `CHK(fault, e[27])
    end else if (pclk === 1'b0) begin
      `CHK(fault, 1'b0)
    end
    pclk_prev = pclk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask : step

  // Looked at mid-cycle, then back on a rising edge for the next drive
  task automatic expect_mode(input mode_e m);
    @(negedge mclk);
    `CHK(mode, m)
    `CHK(pll_en, m[1])
    `CHK(rdy, 1'b1)
    @(posedge mclk);
  endtask : expect_mode

  task automatic done_test(input string s);
    $display("test %s finished", s);
  endtask : done_test

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    en = 1'b0;
    lock = 1'b0;
    cm_high = 1'b1;
    cm_ok = 1'b0;
    ls = 2'b11;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    tx.preamble(8);
    expect_mode(mode_shutdown);
    done_test("shutdown");
    en <= 1'b1;
    tx.preamble(60);
    expect_mode(mode_standby);
    cm_high <= 1'b0;
    cm_ok <= 1'b1;
    tx.preamble(4);
    expect_mode(mode_acquire);
    lock <= 1'b1;
    tx.preamble(6);
    expect_mode(mode_acquire);
    done_test("wake");
    // Every legal lane code reaches receive; lock loss drops back first
    for (int c = 0; c < 3; c++) begin
      lock <= 1'b0;
      tx.preamble(4);
      expect_mode(mode_acquire);
      ls <= 2'(c);
      lock <= 1'b1;
      tx.preamble(4);
      expect_mode(mode_receive);
    end
    done_test("lanes");
    // Three-lane frames only: longer frames fall below the slow-clock limit
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr_next(lfsr_next(rnd));
      bad = (k == 3 || k == 4);
      tx.send_frame(rnd[26:0], bad, 3);
      exp_q.push_back({bad, rnd[26:0]});
    end
    // One more good frame pushes the last queued pixel out; its own word stays behind
    tx.send_frame(~rnd[26:0], 1'b0, 3);
    tx.preamble(4);
    `CHK(exp_q.size(), 0)
    expect_mode(mode_receive);
    done_test("frames");
    cm_high <= 1'b1;
    tx.preamble(4);
    expect_mode(mode_standby);
    cm_high <= 1'b0;
    tx.preamble(8);
    expect_mode(mode_receive);
    step(30);
    expect_mode(mode_standby);
    done_test("standby");
    en <= 1'b0;
    step(120);
    expect_mode(mode_shutdown);
    done_test("off");
    finish_test();
  end

  // Whole run is about 600 cycles; ten times that means a hang
  initial begin
    repeat (6000) @(posedge mclk);
    miscompares++;
    finish_test();
  end
endmodule : test_serial_pixel_deserializer
`default_nettype wire
